// File: knock_processor_spi_config_tb_top.sv
`timescale 1ns/1ps
module knock_processor_spi_config_tb_top;
	logic        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, test_pin = 1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, lf = 32'h9956;
	logic        pready, pslverr, er, chan, pd, integ, werr;
	logic [5:0]  center, gain;
	logic [4:0]  tcode;
	logic [3:0]  div, mux;
	logic [7:0]  ex [5] = '{8'h0A, 8'h94, 8'hC3, 8'hE7, 8'h40};
	int          err_count = 0, check_count = 0, wep = 0, cyc = 0;
	int          m_c = 0, m_g = 0, m_t = 0, m_s = 0, m_p = 1, m_h = 0;
	int          bad [4] = '{1, 7, 9, 15};
	kspc_link_if link ();
	kspc_host i_kspc_host (.clk(clk), .sys_rst(sys_rst), .link(link.host), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	kspc_device i_kspc_device (.clk(clk), .sys_rst(sys_rst), .link(link.dev), .test_pin(test_pin),
		.center_code_field(center), .gain_code_field(gain), .time_code_field(tcode), .channel_pick_bit(chan),
		.divider_code_bit(div), .mux_select(mux), .buffer_power_down(pd), .integrating(integ), .word_error(werr));
	kspc_checker i_kspc_checker (.clk(clk), .sys_rst(sys_rst), .cs_n(link.cs_n), .sck(link.sck), .si(link.si),
		.so_out(link.so_out), .so_oe(link.so_oe), .int_hold(link.int_hold));
	always #20 clk = ~clk;
	// cycle ceiling and rejected word pulses
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (werr === 1'b1) wep <= wep + 1;
		if (cyc == 20000) begin
			err_count++;
			conclude();
		end
	end
	function logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task check_all;
		logic [3:0] mx;
		mx = test_pin ? 4'h0 : m_s[4:1];
		chk(center, m_c);
		chk(gain, m_g);
		chk(tcode, m_t);
		chk(chan, m_s[0]);
		chk(div, m_p[4:1]);
		chk(mux, mx);
		chk(pd, mx == 4'h3);
		chk(link.so_oe, !m_p[0]);
		chk(integ, m_h[0]);
		apb(0, kspc_pkg::REG_STATUS, 0);
		chk(rd[1], !m_p[0]);
	endtask : check_all
	// wait end of frame, update model, compare
	task fin(input logic [7:0] w, input int n);
		int i;
		i = 0;
		rd = 1;
		while (rd[0] === 1'b1 && i < 300) begin
			apb(0, kspc_pkg::REG_STATUS, 0);
			i++;
		end
		chk(rd[0], 0);
		repeat (4) @(posedge clk);
		if (n == 8) chk(link.so_out, w[7]);
		if (n == 8) case (w[7:6])
			2'h0: m_c = w[5:0];
			2'h1: m_p = w[5:0];
			2'h2: m_g = w[5:0];
			default: if (w[5]) m_s = w[4:0]; else m_t = w[4:0];
		endcase
		check_all();
	endtask : fin
	task send(input logic [7:0] w, input int n, input logic h);
		m_h = h;
		apb(1, kspc_pkg::REG_CTRL, n * 16 + h);
		apb(1, kspc_pkg::REG_TXDATA, w);
		fin(w, n);
	endtask : send
	task end_test(input string s);
		$display("test %s done", s);
	endtask : end_test
	task conclude;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	initial begin
		int k, e;
		repeat (4) @(posedge clk);
		sys_rst <= 0;
		check_all();
		end_test("reset");
		// one word per address, loaded in hold
		for (int k = 0; k < 5; k++) begin
			test_pin <= !k[0];
			send(ex[k], 8, 0);
		end
		end_test("examples");
		// random words, pins and modes
		for (k = 0; k < 24; k++) begin
			lf = lfsr(lf);
			test_pin <= lf[9];
			send(lf[7:0], 8, lf[8]);
		end
		end_test("random");
		// wrong bit counts rejected
		for (k = 0; k < 4; k++) begin
			lf = lfsr(lf);
			e = wep;
			send(lf[7:0], bad[k], 0);
			chk(wep, e + 1);
		end
		end_test("counts");
		// unmapped read, write while busy
		apb(0, 12'h0FC, 0);
		chk(er, 1);
		chk(rd, 0);
		apb(1, kspc_pkg::REG_CTRL, 32'h80);
		apb(1, kspc_pkg::REG_TXDATA, 8'h3F);
		apb(1, kspc_pkg::REG_TXDATA, 8'h01);
		chk(er, 1);
		m_h = 0;
		fin(8'h3F, 8);
		end_test("refused");
		conclude();
	end
endmodule : knock_processor_spi_config_tb_top

// File: kspc_checker.sv
`timescale 1ns/1ps
module kspc_checker (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so_out,
	input wire logic so_oe,
	input wire logic int_hold
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// link framing and bit timing
	chk_sel_sck_low: assert property ($fell(cs_n) |-> !sck [*5])
		else $error("sck not low after select");
	chk_desel_sck_low: assert property ($rose(cs_n) |-> $past(!sck))
		else $error("sck not low at deselect");
	chk_sck_high_len: assert property ($rose(sck) |-> sck [*5] ##1 !sck)
		else $error("sck high phase wrong");
	chk_sck_low_len: assert property ($fell(sck) |-> !sck [*5])
		else $error("sck low phase wrong");
	chk_idle_no_sck: assert property (cs_n |-> !sck)
		else $error("sck moves outside frame");
	chk_si_stable_high: assert property (sck |-> $stable(si))
		else $error("si changes while sck high");
	chk_desel_gap_len: assert property ($rose(cs_n) |-> cs_n [*5])
		else $error("deselect gap too short");
	chk_oe_frame_hold: assert property (!cs_n && $past(!cs_n) |-> $stable(so_oe))
		else $error("so_oe changes inside frame");
	// main scenarios seen
	cov_frame: cover property ($rose(cs_n));
	cov_oe: cover property ($rose(so_oe));
	cov_integ: cover property ($rose(int_hold));
endmodule : kspc_checker

// File: kspc_device.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RL1] one eight-bit word per chip select low
// [RL2] sample serial input on falling serial clock
// [RL3] words travel most significant bit first
// [RL4] split word into address and value fields
// [RL5] all words accepted during hold
// [RL6] address 00 loads bandpass centre code
// [RL7] centre codes 0..63 select fixed frequencies
// [RL8] address 10 loads gain code
// [RL9] gain codes 0..63 select fixed gains
// [RL10] address 110 loads time constant code
// [RL11] time codes 0..31 select fixed constants
// [RL12] address 111 loads test/channel, bit0 channel
// [RL13] diagnostic bits act only when test low
// [RL14] address 01 loads divider and output state
// [RL15] top divider bit is ignored
// [RL16] test mux follows diagnostic selection
// [RL17] antialias evaluation powers output buffer down
// [RL18] integrate/hold high integrates, low holds
// [RL19] commit on select rise after clean eight pulses
// [RL20] wrong bit count leaves settings unchanged
// [RL21] drive bit 1 floats output, 0 drives
// [RL22] divider codes 0..8 map 4..24 MHz
// [RL23] settings hold until valid word commits
// [RL24] decode two bits first, then third bit
module kspc_device (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	kspc_link_if.dev        link,
	input  wire logic       test_pin,
	output logic [5:0]      center_code_field,
	output logic [5:0]      gain_code_field,
	output logic [4:0]      time_code_field,
	output logic            channel_pick_bit,
	output logic [3:0]      divider_code_bit,
	output logic [3:0]      mux_select,
	output logic            buffer_power_down,
	output logic            integrating,
	output logic            word_error
);
	logic [5:0] center_r, center_nxt;
	logic [5:0] gain_r, gain_nxt;
	logic [4:0] time_r, time_nxt;
	logic [4:0] test_r, test_nxt;
	logic [5:0] presc_r, presc_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic       sck_d_r, cs_d_r;
	logic       si_d_r; // serial input as it stood before the clock fell
	logic       bad_r, bad_nxt;
	logic [3:0] mux_r, mux_nxt;
	logic       pd_r, pd_nxt;
	logic       integ_r, integ_nxt;
	logic       err_r, err_nxt;
	logic       so_r, so_nxt, soe_r, soe_nxt;
	logic       sck_fall, cs_fall, cs_rise, cs_low;

	// edge detection on the link pins
	assign sck_fall = sck_d_r & ~link.sck;
	assign cs_fall  = cs_d_r & ~link.cs_n;
	assign cs_rise  = ~cs_d_r & link.cs_n;
	assign cs_low   = ~link.cs_n;

	// shift, count and commit
	always_comb begin
		shift_nxt  = shift_r;
		cnt_nxt    = cnt_r;
		bad_nxt    = bad_r;
		err_nxt    = 1'b0;
		center_nxt = center_r;
		gain_nxt   = gain_r;
		time_nxt   = time_r;
		test_nxt   = test_r;
		presc_nxt  = presc_r;
		if (cs_fall) begin
			cnt_nxt = 4'h0;
			bad_nxt = link.sck; // see [RL19]
		end else if (cs_low && sck_fall) begin // see [RL2]
			shift_nxt = {shift_r[6:0], si_d_r}; // see [RL3]
			if (cnt_r == kspc_pkg::BIT_CNT_DONE)
				bad_nxt = 1'b1; // see [RL20]
			else
				cnt_nxt = cnt_r + 4'h1;
		end
		// commit happens whether integrating or holding, see [RL5]
		if (cs_rise) begin
			if (!bad_r && cnt_r == kspc_pkg::BIT_CNT_DONE && !sck_d_r) begin // see [RL1] see [RL19] see [RL23]
				case (shift_r[7:6]) // see [RL4] see [RL24]
					kspc_pkg::ADDR_CENTER:   center_nxt = shift_r[kspc_pkg::WIDE_MSB:0]; // see [RL6] see [RL7]
					kspc_pkg::ADDR_PRESCALE: presc_nxt  = shift_r[kspc_pkg::WIDE_MSB:0]; // see [RL14]
					kspc_pkg::ADDR_GAIN:     gain_nxt   = shift_r[kspc_pkg::WIDE_MSB:0]; // see [RL8] see [RL9]
					default: begin
						if (shift_r[5] == kspc_pkg::SUB_TIME)
							time_nxt = shift_r[kspc_pkg::NARROW_MSB:0]; // see [RL10] see [RL11]
						else
							test_nxt = shift_r[kspc_pkg::NARROW_MSB:0]; // see [RL12]
					end
				endcase
			end else begin
				err_nxt = 1'b1; // see [RL20]
			end
		end
	end

	// derived outputs
	always_comb begin
		mux_nxt   = kspc_pkg::DIAG_INTEG;
		if (!test_pin)
			mux_nxt = test_r[kspc_pkg::DIAG_MSB:kspc_pkg::DIAG_LSB]; // see [RL13] see [RL16]
		pd_nxt    = (mux_nxt == kspc_pkg::DIAG_AAF); // see [RL17]
		integ_nxt = link.int_hold; // see [RL18]
		soe_nxt   = ~presc_r[kspc_pkg::HIZ_BIT]; // see [RL21]
		so_nxt    = shift_r[7];
	end

	// register stage
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			center_r <= kspc_pkg::CENTER_RST;
			gain_r   <= kspc_pkg::GAIN_RST;
			time_r   <= kspc_pkg::TIME_RST;
			test_r   <= kspc_pkg::TEST_RST;
			presc_r  <= kspc_pkg::PRESCALE_RST;
			shift_r  <= 8'h00;
			cnt_r    <= 4'h0;
			bad_r    <= 1'b1;
			sck_d_r  <= 1'b0;
			si_d_r   <= 1'b0;
			cs_d_r   <= 1'b1;
			mux_r    <= kspc_pkg::DIAG_INTEG;
			pd_r     <= 1'b0;
			integ_r  <= 1'b0;
			err_r    <= 1'b0;
			so_r     <= 1'b0;
			soe_r    <= 1'b0;
		end else begin
			center_r <= center_nxt;
			gain_r   <= gain_nxt;
			time_r   <= time_nxt;
			test_r   <= test_nxt;
			presc_r  <= presc_nxt;
			shift_r  <= shift_nxt;
			cnt_r    <= cnt_nxt;
			bad_r    <= bad_nxt;
			sck_d_r  <= link.sck;
			si_d_r   <= link.si; // host moves data in the same cycle as the clock falls
			cs_d_r   <= link.cs_n;
			mux_r    <= mux_nxt;
			pd_r     <= pd_nxt;
			integ_r  <= integ_nxt;
			err_r    <= err_nxt;
			so_r     <= so_nxt;
			soe_r    <= soe_nxt;
		end
	end

	assign center_code_field = center_r;
	assign gain_code_field   = gain_r;
	assign time_code_field   = time_r;
	assign channel_pick_bit  = test_r[kspc_pkg::CHAN_BIT];
	// spare divider bit stays unused, see [RL15]
	assign divider_code_bit  = presc_r[kspc_pkg::DIV_MSB:kspc_pkg::DIV_LSB]; // see [RL22]
	assign mux_select        = mux_r;
	assign buffer_power_down = pd_r;
	assign integrating       = integ_r;
	assign word_error        = err_r;
	assign link.so_out       = so_r;
	assign link.so_oe        = soe_r;
endmodule : kspc_device

// File: kspc_host.sv
`timescale 1ns/1ps
module kspc_host (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	kspc_link_if.host        link,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	kspc_pkg::kspc_host_e st_r, st_nxt;
	logic [7:0]  data_r, data_nxt;
	logic [3:0]  bits_r, bits_nxt;
	logic [3:0]  sent_r, sent_nxt;
	logic [7:0]  tim_r, tim_nxt;
	logic        hold_r, hold_nxt;
	logic        cs_r, cs_nxt, sck_r, sck_nxt, si_r, si_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic        rdy_r, rdy_nxt, err_r, err_nxt;
	logic        acc, wr, busy;
	logic        half_done;

	assign acc       = psel & penable & ~rdy_r;
	assign wr        = acc & pwrite;
	assign busy      = (st_r != kspc_pkg::HS_IDLE);
	assign half_done = (tim_r == 8'(kspc_pkg::SCK_HALF_CYC - 1));

	// serial engine and apb answer
	always_comb begin
		st_nxt   = st_r;
		data_nxt = data_r;
		bits_nxt = bits_r;
		sent_nxt = sent_r;
		hold_nxt = hold_r;
		cs_nxt   = cs_r;
		sck_nxt  = sck_r;
		si_nxt   = si_r;
		tim_nxt  = half_done ? 8'h00 : tim_r + 8'h01;
		rd_nxt   = 32'h0000_0000;
		rdy_nxt  = acc;
		err_nxt  = 1'b0;
		if (acc) begin
			case (paddr)
				kspc_pkg::REG_TXDATA: begin
					if (wr && !busy) begin
						data_nxt = pwdata[7:0];
						st_nxt   = kspc_pkg::HS_SEL;
						tim_nxt  = 8'h00;
					end else if (wr) begin
						err_nxt = 1'b1;
					end
					rd_nxt = {24'h000000, data_r};
				end
				kspc_pkg::REG_CTRL: begin
					if (wr) begin
						hold_nxt = pwdata[kspc_pkg::CTRL_HOLD_BIT];
						bits_nxt = pwdata[kspc_pkg::CTRL_BITS_LSB+3:kspc_pkg::CTRL_BITS_LSB];
					end
					rd_nxt = {24'h000000, bits_r, 3'h0, hold_r};
				end
				kspc_pkg::REG_STATUS: rd_nxt = {30'h0, link.so_oe, busy};
				default: err_nxt = 1'b1;
			endcase
		end
		if (busy && half_done) begin
			case (st_r)
				kspc_pkg::HS_SEL: begin
					cs_nxt   = 1'b0; // clock already low
					sent_nxt = 4'h0;
					si_nxt   = data_r[7];
					st_nxt   = (bits_r == 4'h0) ? kspc_pkg::HS_LAST : kspc_pkg::HS_LOW;
				end
				kspc_pkg::HS_LOW: begin
					sck_nxt = 1'b1;
					st_nxt  = kspc_pkg::HS_HIGH;
				end
				kspc_pkg::HS_HIGH: begin
					sck_nxt  = 1'b0; // device samples here
					sent_nxt = sent_r + 4'h1;
					data_nxt = {data_r[6:0], data_r[7]};
					si_nxt   = data_r[6];
					st_nxt   = (sent_r + 4'h1 == bits_r) ? kspc_pkg::HS_LAST : kspc_pkg::HS_LOW;
				end
				kspc_pkg::HS_LAST: begin
					cs_nxt = 1'b1;
					st_nxt = kspc_pkg::HS_DESEL;
				end
				kspc_pkg::HS_DESEL: st_nxt = kspc_pkg::HS_IDLE;
				default: st_nxt = kspc_pkg::HS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r   <= kspc_pkg::HS_IDLE;
			data_r <= 8'h00;
			bits_r <= 4'h8;
			sent_r <= 4'h0;
			tim_r  <= 8'h00;
			hold_r <= 1'b0;
			cs_r   <= 1'b1;
			sck_r  <= 1'b0;
			si_r   <= 1'b0;
			rd_r   <= 32'h0000_0000;
			rdy_r  <= 1'b0;
			err_r  <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			data_r <= data_nxt;
			bits_r <= bits_nxt;
			sent_r <= sent_nxt;
			tim_r  <= tim_nxt;
			hold_r <= hold_nxt;
			cs_r   <= cs_nxt;
			sck_r  <= sck_nxt;
			si_r   <= si_nxt;
			rd_r   <= rd_nxt;
			rdy_r  <= rdy_nxt;
			err_r  <= err_nxt;
		end
	end

	assign link.cs_n     = cs_r;
	assign link.sck      = sck_r;
	assign link.si       = si_r;
	assign link.int_hold = hold_r;
	assign prdata        = rd_r;
	assign pready        = rdy_r;
	assign pslverr       = err_r;
endmodule : kspc_host

// File: kspc_link_if.sv
`timescale 1ns/1ps
interface kspc_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so_out;
	logic so_oe;
	logic int_hold;
	modport dev  (input cs_n, input sck, input si, input int_hold, output so_out, output so_oe);
	modport host (output cs_n, output sck, output si, output int_hold, input so_out, input so_oe);
endinterface : kspc_link_if

// File: kspc_pkg.sv
package kspc_pkg;
	// word framing
	localparam int          WORD_BITS     = 8;
	localparam logic [3:0]  BIT_CNT_DONE  = 4'h8;
	// address fields, two-bit group then three-bit group
	localparam logic [1:0]  ADDR_CENTER   = 2'h0;
	localparam logic [1:0]  ADDR_PRESCALE = 2'h1;
	localparam logic [1:0]  ADDR_GAIN     = 2'h2;
	localparam logic [1:0]  ADDR_LONG     = 2'h3;
	localparam logic        SUB_TIME      = 1'h0;
	localparam logic        SUB_TEST      = 1'h1;
	// field positions inside a word
	localparam int          WIDE_MSB      = 5;
	localparam int          NARROW_MSB    = 4;
	localparam int          CHAN_BIT      = 0;
	localparam int          HIZ_BIT       = 0;
	localparam int          DIV_LSB       = 1;
	localparam int          DIV_MSB       = 4;
	localparam int          SPARE_BIT     = 5;
	localparam int          DIAG_LSB      = 1;
	localparam int          DIAG_MSB      = 4;
	// settings after reset
	localparam logic [5:0]  CENTER_RST    = 6'h00;
	localparam logic [5:0]  GAIN_RST      = 6'h00;
	localparam logic [4:0]  TIME_RST      = 5'h00;
	localparam logic [4:0]  TEST_RST      = 5'h00;
	localparam logic [5:0]  PRESCALE_RST  = 6'h01;
	// diagnostic mux selections
	localparam logic [3:0]  DIAG_INTEG    = 4'h0;
	localparam logic [3:0]  DIAG_SCF      = 4'h1;
	localparam logic [3:0]  DIAG_GAIN     = 4'h2;
	localparam logic [3:0]  DIAG_AAF      = 4'h3;
	// host register map (byte addresses)
	localparam logic [11:0] REG_TXDATA    = 12'h000;
	localparam logic [11:0] REG_CTRL      = 12'h004;
	localparam logic [11:0] REG_STATUS    = 12'h008;
	localparam int          CTRL_HOLD_BIT = 0;
	localparam int          CTRL_BITS_LSB = 4;
	// link timing: serial half period
	localparam int          SCK_HALF_NS   = 200;
	localparam int          CLK_NS        = 40;
	localparam int          SCK_HALF_CYC  = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
	// host states
	typedef enum logic [2:0] {
		HS_IDLE  = 3'h0,
		HS_SEL   = 3'h1,
		HS_LOW   = 3'h3,
		HS_HIGH  = 3'h2,
		HS_LAST  = 3'h6,
		HS_DESEL = 3'h7
	} kspc_host_e;
endpackage : kspc_pkg
